/* File: src/acs_pkg.sv */
// shared constants and carriers for the serial conversion sequencer
package acs_pkg;
  // ----------------------------------------
  // slot timing in serial clock edges
  // ----------------------------------------
  localparam logic [4:0] SLOT_EDGES = 5'h10;
  localparam logic [4:0] TRACK_LAST_FALL = 5'h03;
  localparam logic [4:0] HOLD_FALL = 5'h04;
  localparam logic [4:0] FIRST_DATA_FALL = 5'h05;
  localparam logic [3:0] CTRL_LAST_RISE = 4'h7;
  localparam logic [3:0] SLOT_LAST_RISE = 4'hf;
  // ----------------------------------------
  // control byte layout and reset values
  // ----------------------------------------
  localparam int CTRL_BITS = 8;
  localparam int ADDR_MSB = 5;
  localparam int ADDR_LSB = 3;
  localparam int RES_BITS = 12;
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] RESET_CHANNEL = 3'h0;
  localparam logic [7:0] RESET_CTRL = 8'h00;

  // sampled pins of the serial port
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } acs_pins_t;

  // request to the converter core
  typedef struct packed {
    logic start;
    logic [2:0] channel;
  } acs_conv_req_t;
endpackage

/* File: src/acs_sequencer.sv */
// serial port sequencer and result buffer of the eight-channel converter
// Overview of operation
// - first 3 serial cycles of a slot track, the next 13 hold and convert.
// - data output is driven only while chip select is low.
// - serial clock edges while chip select is high change nothing.
// - falling edges 1-4 send zeros, edges 5-16 send the result msb first.
// - in continuous frames each 16-edge slot restarts tracking, hold at edge 4.
// - select falling with clock high starts tracking at next clock fall.
// - select falling with clock low tracks at once, counts as fall one.
// - select and clock falling together also enter tracking.
// - control byte is taken on the first 8 rising edges of each slot.
// - a captured channel code applies to the following conversion.
// - byte bits 5..3 choose input 0..7 as a plain binary index.
// - byte bits 7, 6, 2, 1 and 0 are ignored.
// - after reset the first conversion uses input 0.
// - results pass as unsigned straight binary 12-bit codes.
// - powered down while deselected and between fall 16 and the next fall 1.

// ----------------------------------------
// result buffer
// ----------------------------------------
module acs_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // sized to the count so that a depth equal to a power of two is not cut to zero
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic next_in_ready, push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    next_in_ready = (next_count != FULL);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_in_ready;
    end
  end

  // storage needs no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// ----------------------------------------
// sequencer top
// ----------------------------------------
module acs_sequencer #(
  parameter int RES_W = 12,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  output logic track,
  output logic power_down,
  output acs_pkg::acs_conv_req_t conv_req,
  input wire logic [RES_W-1:0] conv_data,
  input wire logic conv_valid,
  output logic conv_ready
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  acs_pkg::acs_pins_t pin_s1, pin_s2, pin_p;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1 <= 3'h4;
      pin_s2 <= 3'h4;
      pin_p <= 3'h4;
    end else begin
      pin_s1 <= '{cs_n: cs_n, sclk: sclk, din: din};
      pin_s2 <= pin_s1;
      pin_p <= pin_s2;
    end
  end

  logic act, cs_fall, sclk_fall, sclk_rise;
  assign act = !pin_s2.cs_n;
  assign cs_fall = pin_p.cs_n && !pin_s2.cs_n;
  assign sclk_fall = act && !cs_fall && pin_p.sclk && !pin_s2.sclk;
  assign sclk_rise = act && !cs_fall && !pin_p.sclk && pin_s2.sclk;

  // ----------------------------------------
  // result buffer in the data path
  // ----------------------------------------
  logic [RES_W-1:0] f_data;
  logic f_valid, f_pop;

  acs_fifo #(.WIDTH(RES_W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(conv_data),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );

  // ----------------------------------------
  // slot sequencing and shifting
  // ----------------------------------------
  logic [4:0] fall_cnt, next_fall;
  logic [3:0] rise_cnt, next_rise;
  logic [7:0] ctrl, next_ctrl;
  logic [2:0] pend, next_pend;
  logic [RES_W-2:0] sh, next_sh;
  logic next_dout, next_oe, next_track, next_pd;
  acs_pkg::acs_conv_req_t next_req;

  always_comb begin
    next_fall = fall_cnt;
    next_rise = rise_cnt;
    next_ctrl = ctrl;
    next_pend = pend;
    next_sh = sh;
    next_dout = dout;
    next_req = '{start: 1'b0, channel: conv_req.channel};
    f_pop = 1'b0;
    if (cs_fall) begin
      // a simultaneous clock fall shows up here as clock already low
      next_rise = '0;
      next_dout = 1'b0;
      next_req.channel = pend;
      next_fall = pin_s2.sclk ? 5'h00 : 5'h01;
    end else if (act) begin
      if (sclk_fall) begin
        if (fall_cnt == acs_pkg::SLOT_EDGES) begin
          next_fall = 5'h01;
          next_req.channel = pend;
        end else begin
          next_fall = fall_cnt + 5'h01;
        end
        next_req.start = (next_fall == acs_pkg::HOLD_FALL);
        if (next_fall < acs_pkg::FIRST_DATA_FALL) begin
          next_dout = 1'b0;
        end else if (next_fall == acs_pkg::FIRST_DATA_FALL) begin
          // an empty buffer sends an all-zero code rather than stale data
          f_pop = f_valid;
          {next_dout, next_sh} = f_valid ? f_data : '0;
        end else begin
          {next_dout, next_sh} = {sh, 1'b0};
        end
      end
      if (sclk_rise) begin
        if (rise_cnt <= acs_pkg::CTRL_LAST_RISE) begin
          next_ctrl = {ctrl[6:0], pin_s2.din};
        end
        if (rise_cnt == acs_pkg::CTRL_LAST_RISE) begin
          next_pend = next_ctrl[acs_pkg::ADDR_MSB:acs_pkg::ADDR_LSB];
        end
        // relies on the host giving whole 16-edge slots
        next_rise = (rise_cnt == acs_pkg::SLOT_LAST_RISE) ? '0 : rise_cnt + 4'h1;
      end
    end
    next_oe = act;
    next_track = act && !cs_fall ? (next_fall != '0 && next_fall <= acs_pkg::TRACK_LAST_FALL)
                                 : (cs_fall && !pin_s2.sclk);
    next_pd = !act || (next_fall == acs_pkg::SLOT_EDGES);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fall_cnt <= '0;
      rise_cnt <= '0;
      ctrl <= acs_pkg::RESET_CTRL;
      pend <= acs_pkg::RESET_CHANNEL;
      sh <= '0;
      dout <= 1'b0;
      dout_oe <= 1'b0;
      track <= 1'b0;
      power_down <= 1'b1;
      conv_req <= '{start: 1'b0, channel: acs_pkg::RESET_CHANNEL};
    end else begin
      fall_cnt <= next_fall;
      rise_cnt <= next_rise;
      ctrl <= next_ctrl;
      pend <= next_pend;
      sh <= next_sh;
      dout <= next_dout;
      dout_oe <= next_oe;
      track <= next_track;
      power_down <= next_pd;
      conv_req <= next_req;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_last_track_fall;
    sclk_fall && fall_cnt == acs_pkg::TRACK_LAST_FALL;
  endsequence

  sequence s_hold_begins;
    conv_req.start && !track && !power_down;
  endsequence

  a_hold_after_track: assert property (@(posedge clk) disable iff (rst)
    s_last_track_fall |=> s_hold_begins)
    else $error("hold did not begin on fall four");

  a_oe_follows_cs: assert property (@(posedge clk) disable iff (rst)
    pin_s2.cs_n |=> !dout_oe)
    else $error("data output driven while deselected");

  a_idle_clock_ignored: assert property (@(posedge clk) disable iff (rst)
    pin_s2.cs_n && pin_p.cs_n |=> $stable(fall_cnt) && $stable(ctrl) && $stable(pend))
    else $error("state changed while deselected");

  a_lead_zeros: assert property (@(posedge clk) disable iff (rst)
    sclk_fall && fall_cnt < acs_pkg::HOLD_FALL |=> !dout)
    else $error("leading bit was not zero");

  a_msb_first: assert property (@(posedge clk) disable iff (rst)
    sclk_fall && fall_cnt == acs_pkg::HOLD_FALL && f_valid |=> dout == $past(f_data[RES_W-1]))
    else $error("result msb not sent on fall five");

  a_cs_clock_high: assert property (@(posedge clk) disable iff (rst)
    cs_fall && pin_s2.sclk |=> fall_cnt == 5'h00 && !track)
    else $error("tracked before first clock fall");

  a_cs_clock_low: assert property (@(posedge clk) disable iff (rst)
    cs_fall && !pin_s2.sclk |=> fall_cnt == 5'h01 && track)
    else $error("select fall not counted as fall one");

  a_next_channel: assert property (@(posedge clk) disable iff (rst)
    sclk_fall && fall_cnt == acs_pkg::SLOT_EDGES |=> conv_req.channel == $past(pend))
    else $error("channel code not applied at slot start");

  a_addr_bits: assert property (@(posedge clk) disable iff (rst)
    sclk_rise && rise_cnt == acs_pkg::CTRL_LAST_RISE |=> pend == $past(ctrl[4:2]))
    else $error("channel code taken from wrong bits");

  a_gap_power_down: assert property (@(posedge clk) disable iff (rst)
    act && sclk_fall && fall_cnt == 5'h0f |=> power_down ##1 power_down)
    else $error("not powered down after fall sixteen");

  a_track_restart: assert property (@(posedge clk) disable iff (rst)
    sclk_fall && fall_cnt == acs_pkg::SLOT_EDGES |=> track && !power_down && fall_cnt == 5'h01)
    else $error("next slot did not return to tracking");

  a_late_rise_ignored: assert property (@(posedge clk) disable iff (rst)
    sclk_rise && rise_cnt > acs_pkg::CTRL_LAST_RISE |=> $stable(ctrl) && $stable(pend))
    else $error("control byte changed after rise eight");

  a_oe_in_frame: assert property (@(posedge clk) disable iff (rst)
    act |=> dout_oe)
    else $error("data output not driven while selected");

  a_deselect_power_down: assert property (@(posedge clk) disable iff (rst)
    !act |=> power_down)
    else $error("powered up while deselected");

  a_start_one_cycle: assert property (@(posedge clk) disable iff (rst)
    conv_req.start |=> !conv_req.start)
    else $error("hold start lasted more than one cycle");
endmodule

/* File: testbench/acs_host.sv */
// serial host model that frames conversions on the converter's serial port
// ----------------------------------------
// host model
// ----------------------------------------
module acs_host (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic track,
  input wire logic power_down
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
    last = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // mode 0 opens with clock high, 1 with clock low, 2 drops both at once
  task automatic open_frame(input int mode);
    sclk = (mode == 1) ? 1'b0 : 1'b1;
    w(4);
    cs_n = 1'b0;
    if (mode == 2) sclk = 1'b0;
    if (mode == 0) w(4);
  endtask
  // half periods of 4 clk keep every level well above the edge detector's need
  task automatic slot(input logic [7:0] ctrl, input logic skip, output logic [15:0] rx,
                      output logic [15:0] trk, output logic [15:0] pd, output logic [15:0] oe);
    for (int i = 0; i < 16; i++) begin
      if (!(i == 0 && skip)) sclk = 1'b0;
      din = (i < 8) ? ctrl[7-i] : ~din;
      w(4);
      sclk = 1'b1;
      w(4);
      // a released line never shows its old level
      last = dout_oe ? dout : ~last;
      rx[15-i] = last;
      trk[15-i] = track;
      pd[15-i] = power_down;
      oe[15-i] = dout_oe;
    end
  endtask
  task automatic close_frame();
    cs_n = 1'b1;
    w(6);
  endtask
  // clock and data wiggle while deselected
  task automatic stray();
    for (int i = 0; i < 4; i++) begin
      sclk = ~sclk;
      din = ~din;
      w(4);
    end
  endtask
endmodule

/* File: testbench/acs_sequencer_tb_top.sv */
// self-checking bench for the serial conversion sequencer
// ----------------------------------------
// bench top
// ----------------------------------------
module acs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst;
  logic conv_valid;
  logic [11:0] conv_data;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic track;
  logic power_down;
  logic conv_ready;
  acs_pkg::acs_conv_req_t conv_req;
  logic [2:0] chan_seen;
  int mismatches = 0;
  int checks = 0;
  int starts = 0;
  logic [11:0] words [5] = '{12'hfff, 12'h800, 12'h001, 12'h5a3, 12'h123};
  acs_sequencer #(.RES_W(12), .DEPTH(4)) u_dut (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout), .dout_oe(dout_oe), .track(track), .power_down(power_down), .conv_req(conv_req),
    .conv_data(conv_data), .conv_valid(conv_valid), .conv_ready(conv_ready));
  acs_host u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
    .track(track), .power_down(power_down));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (conv_req.start === 1'b1) begin
      starts++;
      chan_seen = conv_req.channel;
    end
  end
  task automatic wc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic run_slot(input logic [7:0] ctrl, input logic skip, input logic [11:0] word, input logic [2:0] chan);
    logic [15:0] rx, trk, pd, oe;
    int s0;
    s0 = starts;
    u_host.slot(ctrl, skip, rx, trk, pd, oe);
    chk(rx, {4'h0, word});
    chk(trk, 16'he000);
    chk(pd, 16'h0001);
    chk(oe, 16'hffff);
    chk(16'(starts - s0), 16'h0001);
    chk({13'h0, chan_seen}, {13'h0, chan});
  endtask
  task automatic end_frame();
    u_host.close_frame();
    chk({14'h0, dout_oe, power_down}, 16'h0001);
  endtask
  initial begin
    #500000;
    mismatches++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    conv_valid = 1'b0;
    conv_data = 12'h000;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({11'h0, dout_oe, track, power_down, conv_req.start, conv_ready}, 16'h0005);
    chk({13'h0, conv_req.channel}, 16'h0000);
    // fifth word must be refused by the full buffer
    for (int k = 0; k < 5; k++) begin
      conv_data = words[k];
      conv_valid = 1'b1;
      if (k == 4) chk({15'h0, conv_ready}, 16'h0000);
      wc(1);
    end
    conv_valid = 1'b0;
    wc(3);
    u_host.open_frame(0);
    run_slot(8'hc7, 1'b0, words[0], 3'h0);
    run_slot(8'h28, 1'b0, words[1], 3'h0);
    end_frame();
    u_host.stray();
    u_host.open_frame(1);
    run_slot(8'h10, 1'b1, words[2], 3'h5);
    end_frame();
    u_host.open_frame(2);
    for (int k = 0; k < 8; k++) begin
      run_slot({k[1:0], k[2:0], k[2:0]}, k == 0, (k == 0) ? words[3] : 12'h000,
               (k == 0) ? 3'h2 : 3'(k - 1));
    end
    end_frame();
    end_sim();
  end
endmodule
